// ### design/gauge_adc_map.svh
// Register offsets, field positions, reset values and timing figures
`ifndef GAUGE_ADC_MAP_SVH
`define GAUGE_ADC_MAP_SVH

`define OFS_STATUS 8'h00
`define OFS_CONTROL 8'h01
`define OFS_ACR_MSB 8'h02
`define OFS_ACR_LSB 8'h03
`define OFS_CHG_HI_MSB 8'h04
`define OFS_CHG_HI_LSB 8'h05
`define OFS_CHG_LO_MSB 8'h06
`define OFS_CHG_LO_LSB 8'h07
`define OFS_VOLT_MSB 8'h08
`define OFS_VOLT_LSB 8'h09
`define OFS_VOLT_HI_MSB 8'h0a
`define OFS_VOLT_HI_LSB 8'h0b
`define OFS_VOLT_LO_MSB 8'h0c
`define OFS_VOLT_LO_LSB 8'h0d
`define OFS_CURR_MSB 8'h0e
`define OFS_CURR_LSB 8'h0f
`define OFS_CURR_HI_MSB 8'h10
`define OFS_CURR_HI_LSB 8'h11
`define OFS_CURR_LO_MSB 8'h12
`define OFS_CURR_LO_LSB 8'h13
`define OFS_TEMP_MSB 8'h14
`define OFS_TEMP_LSB 8'h15
`define OFS_TEMP_HI 8'h16
`define OFS_TEMP_LO 8'h17

`define CTRL_MODE_HI 7
`define CTRL_MODE_LO 6
`define CTRL_PIN_HI 2
`define CTRL_PIN_LO 1
`define CTRL_SHDN 0
`define CTRL_RESET 8'h3c

`define STAT_CHG_WRAP 0
`define STAT_VOLT 1
`define STAT_CURR 2
`define STAT_TEMP 3
`define STAT_CHG_LIM 4

`define ACR_RESET 16'h7fff
`define ACR_FULL 16'hffff
`define LIM16_HI_RESET 16'hffff
`define LIM16_LO_RESET 16'h0000
`define LIM8_HI_RESET 8'hff
`define LIM8_LO_RESET 8'h00

`define VOLT_BITS 14
`define CURR_BITS 12
`define TEMP_BITS 11

`define CORE_CLK_MHZ 10
`define CORE_CLK_HZ 10000000
`define CONV_VOLT_US 33000
`define CONV_CT_US 4500
`define SCAN_IDLE_S 10
`define CONV_VOLT_CYC (`CONV_VOLT_US * `CORE_CLK_MHZ)
`define CONV_CT_CYC (`CONV_CT_US * `CORE_CLK_MHZ)
`define SCAN_IDLE_CYC (`SCAN_IDLE_S * `CORE_CLK_HZ)

`endif

// ### design/gauge_adc_pkg.sv
// Types shared by the gauge sequencer
package gauge_adc_pkg;
  typedef enum logic [1:0] {mode_sleep, mode_single, mode_scan, mode_auto}
    adc_mode_t;
  typedef enum logic [1:0] {pin_off, pin_full_in, pin_alert, pin_both}
    pin_mode_t;
  typedef enum logic [1:0] {chan_volt, chan_curr, chan_temp, chan_none}
    adc_chan_t;
  typedef enum {st_idle, st_conv, st_fetch, st_scan_wait} seq_state_t;
endpackage

// ### design/gauge_adc_sequencer_alerts.sv
// Measurement sequencer, result registers, limits and alert pin
// Overview of operation
// - Mode field resets to sleep; nothing converts until host picks a mode.
// - Single mode converts voltage, current, temperature once, then returns to sleep.
// - Scan converts voltage, current, temperature, idles ten seconds, repeats.
// - Automatic mode repeats the three conversions with no idle time.
// - A mode change waits until the running cycle of conversions ends.
// - Voltage conversion takes 33 ms, current and temperature 4.5 ms.
// - Each result register updates as soon as its own conversion ends.
// - Out-of-limit result sets its flag and, in alert mode, pulls alert low.
// - High limits reset to all ones, low limits to zero; host may rewrite.
// - Sixteen-bit charge accumulator starts at mid-scale; host may rewrite it.
// - In charge-complete mode a low pin forces accumulator to all ones, unless alert is still held low.
// - Voltage is fourteen bits in a sixteen-bit pair, all ones at 23.6 V.
// - Current has twelve bits; the four low bits read zero.
// - Current is excess-32767 coded; all ones is +1.3 A full scale.
// - Charging current is positive, discharging negative.
// - Current limits share the coding; alert above high or below low.
// - Temperature has eleven bits, five low bits zero, 510 K full scale.
// - Temperature limits are one byte, checked against result's top byte.
// - Alert code makes the pin an open-drain alert output.
// - Charge-complete code makes the pin an input; low means battery full.
// - Alert stays low, even after reconfiguration, until alert response ends.
`timescale 1ns/1ns
`default_nettype none
`include "gauge_adc_map.svh"

module gauge_adc_sequencer_alerts #(
  parameter int unsigned CONV_VOLT_CYC = `CONV_VOLT_CYC,
  parameter int unsigned CONV_CT_CYC = `CONV_CT_CYC,
  parameter int unsigned SCAN_IDLE_CYC = `SCAN_IDLE_CYC
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic ara_done,
  input wire logic charge_up,
  input wire logic charge_dn,
  input wire logic alert_or_full_pin_in,
  output logic alert_or_full_pin_out,
  output logic alert_or_full_pin_oe,
  input wire logic adc_clk,
  input wire logic [15:0] adc_sample,
  output logic [1:0] adc_chan
);
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [7:0] ctrl_ff;
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic [15:0] acr_ff;
  logic [15:0] chg_hi_ff, chg_lo_ff, volt_hi_ff, volt_lo_ff;
  logic [15:0] curr_hi_ff, curr_lo_ff;
  logic [7:0] temp_hi_ff, temp_lo_ff;
  logic [15:0] volt_ff, curr_ff, temp_ff;
  logic [7:0] reg_rdata_ff;
  logic alert_ff;
  logic pin_out_ff;
  gauge_adc_pkg::seq_state_t state_ff;
  gauge_adc_pkg::adc_mode_t cyc_mode_ff;
  gauge_adc_pkg::adc_chan_t chan_ff;
  logic [31:0] timer_ff;
  logic req_tgl_ff;
  logic [2:0] ack_sync_ff;
  logic ack_evt;
  logic res_load;
  logic cycle_end;
  logic [15:0] new_word;
  logic [2:0] up_sync_ff, dn_sync_ff;
  logic [1:0] pin_sync_ff;
  logic up_evt, dn_evt;
  gauge_adc_pkg::adc_mode_t mode;
  gauge_adc_pkg::pin_mode_t pin_mode;
  // Converter clock side; ara_dn_q is on the core clock
  logic [1:0] adc_rst_ff;
  logic [2:0] req_sync_ff;
  logic [15:0] adc_word_ff;
  logic ack_tgl_ff;
  logic [1:0] adc_chan_ff;
  logic ara_dn_q;

  assign rst_n = rst_sync_ff[1];
  assign mode = gauge_adc_pkg::adc_mode_t'(
    ctrl_ff[`CTRL_MODE_HI:`CTRL_MODE_LO]);
  assign pin_mode = gauge_adc_pkg::pin_mode_t'(
    ctrl_ff[`CTRL_PIN_HI:`CTRL_PIN_LO]);
  assign reg_rdata = reg_rdata_ff;
  assign alert_or_full_pin_out = pin_out_ff;
  assign alert_or_full_pin_oe = alert_ff;
  assign adc_chan = adc_chan_ff;

  function automatic logic hit(input logic [7:0] ofs);
    hit = reg_wr && (reg_addr == ofs);
  endfunction

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end

  // Pin inputs pass two flops; charge_up and charge_dn get a third flop for the edge
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      up_sync_ff <= 3'h0;
      dn_sync_ff <= 3'h0;
      pin_sync_ff <= 2'h3;
      ack_sync_ff <= 3'h0;
    end
    else
    begin
      up_sync_ff <= {up_sync_ff[1:0], charge_up};
      dn_sync_ff <= {dn_sync_ff[1:0], charge_dn};
      pin_sync_ff <= {pin_sync_ff[0], alert_or_full_pin_in};
      ack_sync_ff <= {ack_sync_ff[1:0], ack_tgl_ff};
    end
  end
  assign up_evt = up_sync_ff[1] && !up_sync_ff[2];
  assign dn_evt = dn_sync_ff[1] && !dn_sync_ff[2];
  assign ack_evt = ack_sync_ff[1] ^ ack_sync_ff[2];
  assign res_load = (state_ff == gauge_adc_pkg::st_fetch) && ack_evt;
  assign cycle_end = res_load && (chan_ff == gauge_adc_pkg::chan_temp);

  // Converter word trimmed to the channel's resolution
  always_comb
  begin
    new_word = adc_word_ff;
    if (chan_ff == gauge_adc_pkg::chan_volt)
      new_word[15-`VOLT_BITS:0] = '0;
    else if (chan_ff == gauge_adc_pkg::chan_curr)
      new_word[15-`CURR_BITS:0] = '0;
    else
      new_word[15-`TEMP_BITS:0] = '0;
  end

  // control resets to sleep mode, alert pin mode
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ctrl_ff <= `CTRL_RESET;
    else if (hit(`OFS_CONTROL))
      ctrl_ff <= reg_wdata;
    // single shot falls back to sleep
    else if (cycle_end && cyc_mode_ff == gauge_adc_pkg::mode_single &&
             mode == gauge_adc_pkg::mode_single)
      ctrl_ff[`CTRL_MODE_HI:`CTRL_MODE_LO] <= 2'h0;
  end

  // Sequencer; the mode is latched per cycle so a change waits its turn
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= gauge_adc_pkg::st_idle;
      cyc_mode_ff <= gauge_adc_pkg::mode_sleep;
      chan_ff <= gauge_adc_pkg::chan_volt;
      timer_ff <= 32'h0;
      req_tgl_ff <= 1'b0;
    end
    else
    begin
      case (state_ff)
        gauge_adc_pkg::st_idle:
        begin
          if (mode != gauge_adc_pkg::mode_sleep)
          begin
            cyc_mode_ff <= mode;
            chan_ff <= gauge_adc_pkg::chan_volt;
            timer_ff <= CONV_VOLT_CYC - 1;
            state_ff <= gauge_adc_pkg::st_conv;
          end
        end
        gauge_adc_pkg::st_conv:
        begin
          if (timer_ff == 32'h0)
          begin
            req_tgl_ff <= ~req_tgl_ff;
            state_ff <= gauge_adc_pkg::st_fetch;
          end
          else
            timer_ff <= timer_ff - 32'h1;
        end
        gauge_adc_pkg::st_fetch:
        begin
          if (ack_evt)
          begin
            // cycle finishes on its latched mode
            if (chan_ff != gauge_adc_pkg::chan_temp)
            begin
              chan_ff <= gauge_adc_pkg::adc_chan_t'(chan_ff + 2'h1);
              timer_ff <= CONV_CT_CYC - 1;
              state_ff <= gauge_adc_pkg::st_conv;
            end
            else if (cyc_mode_ff == gauge_adc_pkg::mode_scan)
            begin
              timer_ff <= SCAN_IDLE_CYC - 1;
              state_ff <= gauge_adc_pkg::st_scan_wait;
            end
            else
              state_ff <= gauge_adc_pkg::st_idle;
          end
        end
        gauge_adc_pkg::st_scan_wait:
        begin
          // A new mode ends the idle at once; no conversion is running
          if (mode != gauge_adc_pkg::mode_scan || timer_ff == 32'h0)
            state_ff <= gauge_adc_pkg::st_idle;
          else
            timer_ff <= timer_ff - 32'h1;
        end
        default:
          state_ff <= gauge_adc_pkg::st_idle;
      endcase
    end
  end

  // each result lands when its own conversion ends
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      volt_ff <= 16'h0;
      curr_ff <= 16'h0;
      temp_ff <= 16'h0;
    end
    else if (res_load)
    begin
      // excess-32767 word is stored as converted
      if (chan_ff == gauge_adc_pkg::chan_volt)
        volt_ff <= new_word;
      else if (chan_ff == gauge_adc_pkg::chan_curr)
        curr_ff <= new_word;
      else
        temp_ff <= new_word;
    end
  end

  // limits start disabled, host writes bytes
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      chg_hi_ff <= `LIM16_HI_RESET;
      chg_lo_ff <= `LIM16_LO_RESET;
      volt_hi_ff <= `LIM16_HI_RESET;
      volt_lo_ff <= `LIM16_LO_RESET;
      curr_hi_ff <= `LIM16_HI_RESET;
      curr_lo_ff <= `LIM16_LO_RESET;
      temp_hi_ff <= `LIM8_HI_RESET;
      temp_lo_ff <= `LIM8_LO_RESET;
    end
    else
    begin
      // high byte at the lower offset
      if (hit(`OFS_CHG_HI_MSB)) chg_hi_ff[15:8] <= reg_wdata;
      if (hit(`OFS_CHG_HI_LSB)) chg_hi_ff[7:0] <= reg_wdata;
      if (hit(`OFS_CHG_LO_MSB)) chg_lo_ff[15:8] <= reg_wdata;
      if (hit(`OFS_CHG_LO_LSB)) chg_lo_ff[7:0] <= reg_wdata;
      if (hit(`OFS_VOLT_HI_MSB)) volt_hi_ff[15:8] <= reg_wdata;
      if (hit(`OFS_VOLT_HI_LSB)) volt_hi_ff[7:0] <= reg_wdata;
      if (hit(`OFS_VOLT_LO_MSB)) volt_lo_ff[15:8] <= reg_wdata;
      if (hit(`OFS_VOLT_LO_LSB)) volt_lo_ff[7:0] <= reg_wdata;
      if (hit(`OFS_CURR_HI_MSB)) curr_hi_ff[15:8] <= reg_wdata;
      if (hit(`OFS_CURR_HI_LSB)) curr_hi_ff[7:0] <= reg_wdata;
      if (hit(`OFS_CURR_LO_MSB)) curr_lo_ff[15:8] <= reg_wdata;
      if (hit(`OFS_CURR_LO_LSB)) curr_lo_ff[7:0] <= reg_wdata;
      if (hit(`OFS_TEMP_HI)) temp_hi_ff <= reg_wdata;
      if (hit(`OFS_TEMP_LO)) temp_lo_ff <= reg_wdata;
    end
  end

  // accumulator starts mid-scale; the host relies on shutdown
  // while it writes, so counting is held off in that state
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      acr_ff <= `ACR_RESET;
    else if (pin_mode == gauge_adc_pkg::pin_full_in && !alert_ff &&
             !pin_sync_ff[1])
      acr_ff <= `ACR_FULL;
    else if (hit(`OFS_ACR_MSB))
      acr_ff[15:8] <= reg_wdata;
    else if (hit(`OFS_ACR_LSB))
      acr_ff[7:0] <= reg_wdata;
    else if (!ctrl_ff[`CTRL_SHDN] && up_evt && !dn_evt)
      acr_ff <= acr_ff + 16'h1;
    else if (!ctrl_ff[`CTRL_SHDN] && dn_evt && !up_evt)
      acr_ff <= acr_ff - 16'h1;
  end

  // Status flags: hardware set wins over clear-on-read
  always_comb
  begin
    nxt_status = status_ff;
    if (reg_rd && reg_addr == `OFS_STATUS)
      nxt_status = 8'h0;
    if (!ctrl_ff[`CTRL_SHDN] && ((up_evt && !dn_evt && acr_ff == 16'hffff) ||
        (dn_evt && !up_evt && acr_ff == 16'h0)))
      nxt_status[`STAT_CHG_WRAP] = 1'b1;
    if (acr_ff > chg_hi_ff || acr_ff < chg_lo_ff)
      nxt_status[`STAT_CHG_LIM] = 1'b1;
    // checked on the word being stored
    if (res_load)
    begin
      if (chan_ff == gauge_adc_pkg::chan_volt &&
          (new_word > volt_hi_ff || new_word < volt_lo_ff))
        nxt_status[`STAT_VOLT] = 1'b1;
      // current limits in the same coding
      if (chan_ff == gauge_adc_pkg::chan_curr &&
          (new_word > curr_hi_ff || new_word < curr_lo_ff))
        nxt_status[`STAT_CURR] = 1'b1;
      if (chan_ff == gauge_adc_pkg::chan_temp &&
          (new_word[15:8] > temp_hi_ff || new_word[15:8] < temp_lo_ff))
        nxt_status[`STAT_TEMP] = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      status_ff <= 8'h0;
    else
      status_ff <= nxt_status;
  end

  // open-drain alert; only ever drives low
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      alert_ff <= 1'b0;
      pin_out_ff <= 1'b0;
    end
    // new flag in alert mode pulls the pin
    else if (pin_mode == gauge_adc_pkg::pin_alert &&
             (nxt_status & ~status_ff) != 8'h0)
      alert_ff <= 1'b1;
    // only the alert response releases it
    else if (ara_done)
      alert_ff <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata_ff <= 8'h0;
    else if (reg_rd)
    begin
      if (reg_addr == `OFS_STATUS) reg_rdata_ff <= status_ff;
      else if (reg_addr == `OFS_CONTROL) reg_rdata_ff <= ctrl_ff;
      else if (reg_addr == `OFS_ACR_MSB) reg_rdata_ff <= acr_ff[15:8];
      else if (reg_addr == `OFS_ACR_LSB) reg_rdata_ff <= acr_ff[7:0];
      else if (reg_addr == `OFS_CHG_HI_MSB) reg_rdata_ff <= chg_hi_ff[15:8];
      else if (reg_addr == `OFS_CHG_HI_LSB) reg_rdata_ff <= chg_hi_ff[7:0];
      else if (reg_addr == `OFS_CHG_LO_MSB) reg_rdata_ff <= chg_lo_ff[15:8];
      else if (reg_addr == `OFS_CHG_LO_LSB) reg_rdata_ff <= chg_lo_ff[7:0];
      else if (reg_addr == `OFS_VOLT_MSB) reg_rdata_ff <= volt_ff[15:8];
      else if (reg_addr == `OFS_VOLT_LSB) reg_rdata_ff <= volt_ff[7:0];
      else if (reg_addr == `OFS_VOLT_HI_MSB) reg_rdata_ff <= volt_hi_ff[15:8];
      else if (reg_addr == `OFS_VOLT_HI_LSB) reg_rdata_ff <= volt_hi_ff[7:0];
      else if (reg_addr == `OFS_VOLT_LO_MSB) reg_rdata_ff <= volt_lo_ff[15:8];
      else if (reg_addr == `OFS_VOLT_LO_LSB) reg_rdata_ff <= volt_lo_ff[7:0];
      else if (reg_addr == `OFS_CURR_MSB) reg_rdata_ff <= curr_ff[15:8];
      else if (reg_addr == `OFS_CURR_LSB) reg_rdata_ff <= curr_ff[7:0];
      else if (reg_addr == `OFS_CURR_HI_MSB) reg_rdata_ff <= curr_hi_ff[15:8];
      else if (reg_addr == `OFS_CURR_HI_LSB) reg_rdata_ff <= curr_hi_ff[7:0];
      else if (reg_addr == `OFS_CURR_LO_MSB) reg_rdata_ff <= curr_lo_ff[15:8];
      else if (reg_addr == `OFS_CURR_LO_LSB) reg_rdata_ff <= curr_lo_ff[7:0];
      else if (reg_addr == `OFS_TEMP_MSB) reg_rdata_ff <= temp_ff[15:8];
      else if (reg_addr == `OFS_TEMP_LSB) reg_rdata_ff <= temp_ff[7:0];
      else if (reg_addr == `OFS_TEMP_HI) reg_rdata_ff <= temp_hi_ff;
      else if (reg_addr == `OFS_TEMP_LO) reg_rdata_ff <= temp_lo_ff;
      else reg_rdata_ff <= 8'h0;
    end
  end

  // Converter side: request toggle in, word captured, ack toggle out.
  // chan_ff is stable while a request is open, so it may be sampled here.
  always_ff @(posedge adc_clk or negedge rst_b)
  begin
    if (!rst_b)
      adc_rst_ff <= 2'h0;
    else
      adc_rst_ff <= {adc_rst_ff[0], 1'b1};
  end

  always_ff @(posedge adc_clk or negedge adc_rst_ff[1])
  begin
    if (!adc_rst_ff[1])
    begin
      req_sync_ff <= 3'h0;
      adc_word_ff <= 16'h0;
      ack_tgl_ff <= 1'b0;
      adc_chan_ff <= 2'h3;
    end
    else
    begin
      req_sync_ff <= {req_sync_ff[1:0], req_tgl_ff};
      adc_chan_ff <= chan_ff;
      if (req_sync_ff[1] ^ req_sync_ff[2])
      begin
        adc_word_ff <= adc_sample;
        ack_tgl_ff <= ~ack_tgl_ff;
      end
    end
  end

  default clocking cb_core @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_temp_stored;
    res_load && chan_ff == gauge_adc_pkg::chan_temp;
  endsequence

  a_single_to_sleep: assert property (
    s_temp_stored ##0 (cyc_mode_ff == gauge_adc_pkg::mode_single &&
    mode == gauge_adc_pkg::mode_single && !reg_wr) |=>
    mode == gauge_adc_pkg::mode_sleep)
    else $error("single cycle did not return to sleep");
  a_cycle_starts_volt: assert property (
    state_ff == gauge_adc_pkg::st_idle && mode != gauge_adc_pkg::mode_sleep
    |=> chan_ff == gauge_adc_pkg::chan_volt &&
    timer_ff == CONV_VOLT_CYC - 1)
    else $error("cycle did not start with voltage");
  a_mode_held: assert property (
    state_ff == gauge_adc_pkg::st_fetch && !ack_evt |=>
    $stable(cyc_mode_ff))
    else $error("cycle mode changed mid cycle");
  a_ct_time: assert property (
    res_load && chan_ff != gauge_adc_pkg::chan_temp |=>
    timer_ff == CONV_CT_CYC - 1)
    else $error("wrong current or temperature time");
  a_curr_low_zero: assert property (
    curr_ff[3:0] == 4'h0 && temp_ff[4:0] == 5'h0)
    else $error("low result bits not zero");
  a_full_forces: assert property (
    pin_mode == gauge_adc_pkg::pin_full_in && !alert_ff &&
    !pin_sync_ff[1] |=> acr_ff == `ACR_FULL)
    else $error("full input did not load accumulator");
  a_alert_stays: assert property (
    alert_ff && !ara_done |=> alert_ff[*2] or (alert_ff ##1 ara_dn_q))
    else $error("alert released without response");
  a_temp_flag: assert property (
    s_temp_stored ##0 new_word[15:8] > temp_hi_ff |=>
    status_ff[`STAT_TEMP])
    else $error("temperature flag not set");
  a_store_result: assert property (
    res_load && chan_ff == gauge_adc_pkg::chan_volt |=>
    volt_ff == $past(new_word))
    else $error("voltage result not stored");

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ara_dn_q <= 1'b0;
    else
      ara_dn_q <= ara_done;
  end
endmodule
`default_nettype wire

// ### dv/gauge_conv_model.sv
// Converter model: answers each channel request with a fixed word
`timescale 1ns/1ns
`default_nettype none
module gauge_conv_model (
  input wire logic adc_clk,
  input wire logic [1:0] adc_chan,
  output logic [15:0] adc_sample
);
  initial adc_sample = 16'h5a5a;
  // Low bits set on purpose so masking in the device is visible
  always @(posedge adc_clk)
  begin
    case (adc_chan)
      2'h0: adc_sample <= 16'hb01f;
      2'h1: adc_sample <= 16'ha84f;
      2'h2: adc_sample <= 16'h96ff;
      // No channel selected: word flips each cycle, never a stale value
      default: adc_sample <= ~adc_sample;
    endcase
  end
endmodule
`default_nettype wire

// ### dv/gauge_adc_sequencer_alerts_test.sv
// Self-checking bench for the gauge sequencer
`timescale 1ns/1ns
`default_nettype none
`include "gauge_adc_map.svh"
module gauge_adc_sequencer_alerts_test;
  logic core_clk = 0, adc_clk = 0, rst_b = 0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic reg_wr = 0, reg_rd = 0, ara_done = 0, chg_low = 0;
  logic chg_up = 0, chg_dn = 0;
  logic pin_out, pin_oe, pin_in;
  logic [1:0] adc_chan;
  logic [15:0] adc_sample, d;
  int fails = 0, n_checks = 0;
  // Pulled up; device and charger can only pull low
  assign pin_in = (pin_oe ? pin_out : 1'b1) & ~chg_low;
  initial forever #50 core_clk = ~core_clk;
  initial
  begin
    #3;
    forever
    begin
      #7 adc_clk = 1'b1;
      #8 adc_clk = 1'b0;
    end
  end
  gauge_adc_sequencer_alerts #(.CONV_VOLT_CYC(40), .CONV_CT_CYC(10),
    .SCAN_IDLE_CYC(100)) DUT (.core_clk(core_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ara_done(ara_done),
    .charge_up(chg_up), .charge_dn(chg_dn), .alert_or_full_pin_in(pin_in),
    .alert_or_full_pin_out(pin_out), .alert_or_full_pin_oe(pin_oe),
    .adc_clk(adc_clk), .adc_sample(adc_sample), .adc_chan(adc_chan));
  gauge_conv_model conv (.adc_clk(adc_clk), .adc_chan(adc_chan),
    .adc_sample(adc_sample));
  task automatic wrap_up;
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e);
    n_checks++;
    if (d !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, d);
      fails++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  // Both bytes in one back-to-back read; the device reads each byte live and does not latch the pair
  task automatic rd16(input logic [7:0] a);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_addr <= a + 8'h01;
    @(negedge core_clk);
    d[15:8] = reg_rdata;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d[7:0] = reg_rdata;
  endtask
  task automatic wait_chan(input logic [1:0] c, input bit eq, output int n);
    int i;
    for (i = 0; i < 2000 && ((adc_chan === c) != eq); i++)
      @(posedge core_clk);
    n = i;
    if (i == 2000)
    begin
      $display("Error adc_chan expected %h seen %h", c, adc_chan);
      fails++;
      wrap_up();
    end
  endtask
  // The temperature code stays up after a cycle, so step off it first
  task automatic run_cycle;
    int n;
    wait_chan(2'h2, 0, n);
    wait_chan(2'h2, 1, n);
    repeat (25) @(posedge core_clk);
  endtask
  task automatic bump(input bit up);
    @(posedge core_clk);
    if (up)
      chg_up <= 1'b1;
    else
      chg_dn <= 1'b1;
    repeat (3) @(posedge core_clk);
    chg_up <= 1'b0;
    chg_dn <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic t_reset;
    rd16(`OFS_CONTROL);
    chk("control", 16'h3c7f);
    rd16(`OFS_ACR_MSB);
    chk("acr", `ACR_RESET);
    rd16(`OFS_VOLT_HI_MSB);
    chk("volt_hi", 16'hffff);
    rd16(`OFS_CURR_LO_MSB);
    chk("curr_lo", 16'h0000);
    rd16(`OFS_TEMP_HI);
    chk("temp_lim", 16'hff00);
  endtask
  task automatic t_mid_change;
    wr(`OFS_CONTROL, 8'h7c);
    wr(`OFS_CONTROL, 8'h3c);
    run_cycle();
    rd16(`OFS_VOLT_MSB);
    chk("volt", 16'hb01c);
    rd16(`OFS_CURR_MSB);
    chk("curr", 16'ha840);
    rd16(`OFS_TEMP_MSB);
    chk("temp", 16'h96e0);
    rd16(`OFS_STATUS);
    chk("status", 16'h003c);
  endtask
  task automatic t_alert;
    wr(`OFS_CURR_HI_MSB, 8'ha8);
    wr(`OFS_CURR_HI_LSB, 8'h3f);
    wr(`OFS_CONTROL, 8'h7c);
    run_cycle();
    @(negedge core_clk);
    d = {15'h0, pin_oe};
    chk("pin_oe", 16'h0001);
    rd16(`OFS_STATUS);
    chk("status", 16'h043c);
    wr(`OFS_CONTROL, 8'h38);
    @(negedge core_clk);
    d = {15'h0, pin_oe};
    chk("pin_oe", 16'h0001);
    @(posedge core_clk);
    ara_done <= 1'b1;
    @(posedge core_clk);
    ara_done <= 1'b0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    d = {15'h0, pin_oe};
    chk("pin_oe", 16'h0000);
  endtask
  task automatic t_acr;
    wr(`OFS_CONTROL, 8'h39);
    wr(`OFS_ACR_MSB, 8'hf0);
    wr(`OFS_ACR_LSB, 8'h01);
    rd16(`OFS_ACR_MSB);
    chk("acr", 16'hf001);
    wr(`OFS_CONTROL, 8'h3b);
    chg_low <= 1'b1;
    repeat (8) @(posedge core_clk);
    rd16(`OFS_ACR_MSB);
    chk("acr", `ACR_FULL);
    chg_low <= 1'b0;
    // Counting resumes once shutdown is cleared
    wr(`OFS_CONTROL, 8'h38);
    bump(1'b0);
    bump(1'b0);
    bump(1'b1);
    rd16(`OFS_ACR_MSB);
    chk("acr", 16'hfffe);
  endtask
  task automatic t_repeat(input logic [7:0] m, input bit idle);
    int n;
    wr(`OFS_CONTROL, m);
    wait_chan(2'h2, 0, n);
    wait_chan(2'h2, 1, n);
    // Temperature slot to next voltage slot is long only with scan idle
    wait_chan(2'h0, 1, n);
    d = {15'h0, n > 60};
    chk("scan_idle", {15'h0, idle});
    wr(`OFS_CONTROL, 8'h3c);
    run_cycle();
    repeat (150) @(posedge core_clk);
    d = {14'h0, adc_chan};
    chk("sleep_chan", 16'h0002);
  endtask
  initial
  begin
    repeat (3) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge core_clk);
    t_reset();
    t_mid_change();
    t_alert();
    t_acr();
    t_repeat(8'hbc, 1'b1);
    t_repeat(8'hfc, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
